// File: hw/scp_cmd_port.sv
// Behaviour
// - Command decoded from select, row, column and write strobes together.
// - Masked lane during write discards data, stored byte unchanged.
// - Masked lane during read goes high impedance two clocks after sampling.
// - Four mask bits govern byte lanes, lowest lane to highest lane.
// - An unnamed mask reference means all four mask bits alike.
// - Activate, read, write, bank precharge act only on selected bank.
// - Activate takes row from address lines, opens it in bank.
// - Read or write takes nine low address bits as column.
// - Precharge flag line on read/write selects auto precharge afterwards.
// - Precharge with flag high closes all banks, else selected bank.
// - Load mode register takes address lines as the opcode.
// - Every input sampled on the rising clock edge.
// - Commands ignored while select sampled high.
// - Clock gate low suspends clocking: power-down, self refresh, suspend.
`timescale 1ns/1ps
`default_nettype none

module scp_cmd_port #(
	parameter int ROW_IDX_W = 4,
	parameter int COL_IDX_W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command, address and mask pins
	input wire scp_pkg::scp_cmd_bus_type cmd_bus,
	// Data lines, split into input, output and enable
	input wire logic [scp_pkg::DATA_W-1:0] data_lines_i,
	output logic [scp_pkg::DATA_W-1:0] data_lines_o,
	output logic [scp_pkg::DATA_W-1:0] data_lines_oe,
	// State shown to the surrounding device
	output logic [scp_pkg::ADDR_W-1:0] mode_opcode,
	output logic mode_load,
	output logic refresh_pulse,
	output logic [scp_pkg::BANKS-1:0] bank_open,
	output scp_pkg::scp_pwr_type power_state
);

	localparam int AW = scp_pkg::BANK_W + ROW_IDX_W + COL_IDX_W;

	if (ROW_IDX_W < 1 || ROW_IDX_W > scp_pkg::ROW_W || COL_IDX_W < 1 || COL_IDX_W > scp_pkg::COL_W)
	begin : g_check
		$error("scp_cmd_port: index widths out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Input sampling

	scp_pkg::scp_cmd_bus_type bus_reg;
	logic [scp_pkg::DATA_W-1:0] din_reg;
	logic cke_prev_reg;

	// Same clock as the controller, so one register stage is the sample
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bus_reg <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
				bank_select: '0, addr_lines: '0, byte_lane_mask: '1};
			din_reg <= scp_pkg::DATA_RST;
			cke_prev_reg <= 1'b1;
		end
		else
		begin
			bus_reg <= cmd_bus;
			din_reg <= data_lines_i;
			cke_prev_reg <= bus_reg.cke;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	wire [2:0] strobe_code = {bus_reg.ras_n, bus_reg.cas_n, bus_reg.we_n};
	wire clock_live = bus_reg.cke;
	scp_pkg::scp_cmd_type cmd;

	always_comb
	begin
		if (bus_reg.cs_n)
			cmd = scp_pkg::CMD_DESELECT;
		else if (strobe_code == scp_pkg::CODE_LOAD_MODE)
			cmd = scp_pkg::CMD_LOAD_MODE;
		else if (strobe_code == scp_pkg::CODE_REFRESH)
			cmd = scp_pkg::CMD_REFRESH;
		else if (strobe_code == scp_pkg::CODE_PRECHARGE)
			cmd = scp_pkg::CMD_PRECHARGE;
		else if (strobe_code == scp_pkg::CODE_ACTIVATE)
			cmd = scp_pkg::CMD_ACTIVATE;
		else if (strobe_code == scp_pkg::CODE_WRITE)
			cmd = scp_pkg::CMD_WRITE;
		else if (strobe_code == scp_pkg::CODE_READ)
			cmd = scp_pkg::CMD_READ;
		else if (strobe_code == scp_pkg::CODE_BURST_STOP)
			cmd = scp_pkg::CMD_BURST_STOP;
		else
			cmd = scp_pkg::CMD_NOP;
	end

	// Only self refresh entry is decoded while the internal clock is held
	wire cmd_live = clock_live && cke_prev_reg;
	wire is_load_mode = cmd_live && (cmd == scp_pkg::CMD_LOAD_MODE);
	wire is_refresh = cmd_live && (cmd == scp_pkg::CMD_REFRESH);
	wire is_precharge = cmd_live && (cmd == scp_pkg::CMD_PRECHARGE);
	wire is_activate = cmd_live && (cmd == scp_pkg::CMD_ACTIVATE);
	wire is_write = cmd_live && (cmd == scp_pkg::CMD_WRITE);
	wire is_read = cmd_live && (cmd == scp_pkg::CMD_READ);

	// Self refresh starts on a refresh whose clock gate just fell
	wire enter_self_refresh = cke_prev_reg && !clock_live && !bus_reg.cs_n
		&& (strobe_code == scp_pkg::CODE_REFRESH);

	////////////////////////////////////////////////////////////////////////////
	// Address fields

	wire [scp_pkg::BANK_W-1:0] bank_sel = bus_reg.bank_select;
	wire [scp_pkg::ROW_W-1:0] row_addr = bus_reg.addr_lines[scp_pkg::ROW_W-1:0];
	wire [scp_pkg::COL_W-1:0] col_addr = bus_reg.addr_lines[scp_pkg::COL_W-1:0];
	wire precharge_flag_line = bus_reg.addr_lines[scp_pkg::PRECHARGE_FLAG_POS];
	wire auto_precharge = precharge_flag_line;
	wire precharge_all = is_precharge && precharge_flag_line;

	////////////////////////////////////////////////////////////////////////////
	// Per-bank row state

	logic [scp_pkg::BANKS-1:0] open_reg;
	logic [scp_pkg::BANKS-1:0] ap_close_reg;
	logic [scp_pkg::ROW_W-1:0] row_reg [scp_pkg::BANKS];
	logic [scp_pkg::BANKS-1:0] bank_hit;

	for (genvar b = 0; b < scp_pkg::BANKS; b++)
	begin : g_bank
		wire this_bank = (bank_sel == scp_pkg::BANK_W'(b));
		wire act_here = is_activate && this_bank;
		wire pre_here = precharge_all || (is_precharge && this_bank);
		wire acc_here = (is_write || is_read) && this_bank && open_reg[b];
		wire open_next = act_here ? 1'b1 : (pre_here || ap_close_reg[b]) ? 1'b0 : open_reg[b];

		assign bank_hit[b] = this_bank;

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				open_reg[b] <= 1'b0;
				ap_close_reg[b] <= 1'b0;
				row_reg[b] <= scp_pkg::ROW_RST;
			end
			else
			begin
				open_reg[b] <= open_next;
				// Burst of one, so the row closes right after the access
				ap_close_reg[b] <= acc_here && auto_precharge && clock_live;
				if (act_here)
				begin
					row_reg[b] <= row_addr;
				end
			end
		end
	end

	wire [scp_pkg::ROW_W-1:0] sel_row = row_reg[bank_sel];
	wire sel_open = |(open_reg & bank_hit);

	////////////////////////////////////////////////////////////////////////////
	// Mode register opcode

	logic [scp_pkg::ADDR_W-1:0] mode_opcode_reg;
	logic mode_load_reg;
	logic refresh_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_opcode_reg <= scp_pkg::MODE_OPCODE_RST;
			mode_load_reg <= 1'b0;
			refresh_reg <= 1'b0;
		end
		else
		begin
			if (is_load_mode)
			begin
				mode_opcode_reg <= bus_reg.addr_lines;
			end
			mode_load_reg <= is_load_mode;
			refresh_reg <= is_refresh;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Array access

	wire [AW-1:0] mem_addr = {bank_sel, sel_row[ROW_IDX_W-1:0], col_addr[COL_IDX_W-1:0]};
	wire wr_go = is_write && sel_open;
	wire rd_go = is_read && sel_open;
	// Mask bit l covers bits 8l..8l+7; high drops that lane
	wire [scp_pkg::LANES-1:0] wr_lanes = ~bus_reg.byte_lane_mask;
	logic [scp_pkg::DATA_W-1:0] mem_rd_data;

	scp_lane_mem #(
		.AW(AW),
		.LANES(scp_pkg::LANES),
		.LANE_W(scp_pkg::LANE_W)
	) u_mem (
		.clk(clk),
		.wr_en(wr_go),
		.wr_lane_en(wr_lanes),
		.wr_addr(mem_addr),
		.wr_data(din_reg),
		.rd_en(rd_go),
		.rd_addr(mem_addr),
		.rd_data(mem_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read pipeline and output mask

	logic rd_valid1_reg;
	logic [scp_pkg::LANES-1:0] mask_d1_reg;
	logic [scp_pkg::DATA_W-1:0] dout_reg;
	logic [scp_pkg::DATA_W-1:0] oe_reg;

	// While the clock is held the pipeline freezes with the lines as they are
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_valid1_reg <= 1'b0;
			mask_d1_reg <= '1;
		end
		else if (clock_live)
		begin
			rd_valid1_reg <= rd_go;
			mask_d1_reg <= bus_reg.byte_lane_mask;
		end
	end

	for (genvar l = 0; l < scp_pkg::LANES; l++)
	begin : g_out_lane
		// Each lane keeps its own mask; a shared mask just drives all four alike
		wire lane_on = rd_valid1_reg && !mask_d1_reg[l];

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				dout_reg[l*scp_pkg::LANE_W +: scp_pkg::LANE_W] <= '0;
				oe_reg[l*scp_pkg::LANE_W +: scp_pkg::LANE_W] <= '0;
			end
			else if (clock_live)
			begin
				dout_reg[l*scp_pkg::LANE_W +: scp_pkg::LANE_W] <= mem_rd_data[l*scp_pkg::LANE_W +: scp_pkg::LANE_W];
				oe_reg[l*scp_pkg::LANE_W +: scp_pkg::LANE_W] <= {scp_pkg::LANE_W{lane_on}};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power state

	logic self_refresh_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			self_refresh_reg <= 1'b0;
		end
		else if (clock_live)
		begin
			self_refresh_reg <= 1'b0;
		end
		else if (enter_self_refresh)
		begin
			self_refresh_reg <= 1'b1;
		end
	end

	// An access still in flight means suspend, not power-down
	wire access_busy = rd_valid1_reg || (|oe_reg);
	scp_pkg::scp_pwr_type pwr_now;

	always_comb
	begin
		if (clock_live)
			pwr_now = scp_pkg::PWR_ACTIVE;
		else if (self_refresh_reg || enter_self_refresh)
			pwr_now = scp_pkg::PWR_SELF_REFRESH;
		else if (access_busy)
			pwr_now = scp_pkg::PWR_CLOCK_SUSPEND;
		else if (|open_reg)
			pwr_now = scp_pkg::PWR_DOWN_ACTIVE;
		else
			pwr_now = scp_pkg::PWR_DOWN_PRECHARGE;
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign data_lines_o = dout_reg;
	assign data_lines_oe = oe_reg;
	assign mode_opcode = mode_opcode_reg;
	assign mode_load = mode_load_reg;
	assign refresh_pulse = refresh_reg;
	assign bank_open = open_reg;
	assign power_state = pwr_now;

endmodule

`default_nettype wire

// File: hw/scp_lane_mem.sv
`timescale 1ns/1ps
`default_nettype none

module scp_lane_mem #(
	parameter int AW = 10,
	parameter int LANES = 4,
	parameter int LANE_W = 8
) (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic wr_en,
	input wire logic [LANES-1:0] wr_lane_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [LANES*LANE_W-1:0] wr_data,
	// Read side
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [LANES*LANE_W-1:0] rd_data
);

	if (AW < 1 || AW > 20 || LANES < 1 || LANE_W < 1)
	begin : g_check
		$error("scp_lane_mem: unsupported shape");
	end

	////////////////////////////////////////////////////////////////////////////
	// One array per lane so a masked lane keeps its stored byte
	for (genvar l = 0; l < LANES; l++)
	begin : g_lane
		logic [LANE_W-1:0] mem [0:(1<<AW)-1];

		always_ff @(posedge clk)
		begin
			if (wr_en && wr_lane_en[l])
			begin
				mem[wr_addr] <= wr_data[l*LANE_W +: LANE_W];
			end
		end

		always_ff @(posedge clk)
		begin
			if (rd_en)
			begin
				rd_data[l*LANE_W +: LANE_W] <= mem[rd_addr];
			end
		end
	end

endmodule

`default_nettype wire

// File: shared/scp_pkg.sv
package scp_pkg;

	// Array shape
	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ADDR_W = 12;
	localparam int ROW_W = 11;
	localparam int COL_W = 9;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DATA_W = 32;

	// Field positions on the address lines
	localparam int PRECHARGE_FLAG_POS = 10;

	// Cycles from the sampling edge to the data phase on the lines
	localparam int MASK_LATENCY = 2;
	localparam int READ_LATENCY = 2;

	// Values after reset
	localparam logic [ADDR_W-1:0] MODE_OPCODE_RST = 12'h000;
	localparam logic [ROW_W-1:0] ROW_RST = 11'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

	// Raw strobe codes {row, column, write}, all active low
	localparam logic [2:0] CODE_LOAD_MODE = 3'h0;
	localparam logic [2:0] CODE_REFRESH = 3'h1;
	localparam logic [2:0] CODE_PRECHARGE = 3'h2;
	localparam logic [2:0] CODE_ACTIVATE = 3'h3;
	localparam logic [2:0] CODE_WRITE = 3'h4;
	localparam logic [2:0] CODE_READ = 3'h5;
	localparam logic [2:0] CODE_BURST_STOP = 3'h6;
	localparam logic [2:0] CODE_NOP = 3'h7;

	typedef enum logic [3:0] {
		CMD_DESELECT,
		CMD_NOP,
		CMD_LOAD_MODE,
		CMD_REFRESH,
		CMD_PRECHARGE,
		CMD_ACTIVATE,
		CMD_WRITE,
		CMD_READ,
		CMD_BURST_STOP
	} scp_cmd_type;

	typedef enum logic [2:0] {
		PWR_ACTIVE,
		PWR_DOWN_PRECHARGE,
		PWR_DOWN_ACTIVE,
		PWR_SELF_REFRESH,
		PWR_CLOCK_SUSPEND
	} scp_pwr_type;

	// Everything the controller drives besides data
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] bank_select;
		logic [ADDR_W-1:0] addr_lines;
		logic [LANES-1:0] byte_lane_mask;
	} scp_cmd_bus_type;

endpackage

// File: test/scp_cmd_port_props.sv
`timescale 1ns/1ps
`default_nettype none

module scp_cmd_port_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire scp_pkg::scp_cmd_bus_type cmd_bus,
	input wire logic [scp_pkg::DATA_W-1:0] data_lines_oe,
	input wire logic [scp_pkg::ADDR_W-1:0] mode_opcode,
	input wire logic mode_load,
	input wire logic refresh_pulse,
	input wire logic [scp_pkg::BANKS-1:0] bank_open
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic cke_q;
	always_ff @(posedge clk) cke_q <= rst | cmd_bus.cke;
	wire logic [2:0] code = {cmd_bus.ras_n, cmd_bus.cas_n, cmd_bus.we_n};
	wire logic go = cmd_bus.cke && cke_q && !cmd_bus.cs_n;
	// The open flag that gates a read is the one seen one edge after the command
	wire logic rd_cmd = go && code == scp_pkg::CODE_READ;

	function automatic logic [31:0] lane_oe(input logic [3:0] m);
		return {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	load_mode_a: assert property (go && code == scp_pkg::CODE_LOAD_MODE ##1 cmd_bus.cke
		|=> mode_load && mode_opcode == $past(cmd_bus.addr_lines, 2)) else $error("opcode not loaded");
	deselect_a: assert property (cmd_bus.cs_n && cke_q && cmd_bus.cke ##1 cmd_bus.cke
		|=> !mode_load && !refresh_pulse) else $error("deselected command acted");
	refresh_cmd_a: assert property (go && code == scp_pkg::CODE_REFRESH ##1 cmd_bus.cke
		|=> refresh_pulse) else $error("refresh not decoded");
	activate_a: assert property (go && code == scp_pkg::CODE_ACTIVATE ##1 cmd_bus.cke
		|=> bank_open[$past(cmd_bus.bank_select, 2)]) else $error("bank not opened");
	pre_all_a: assert property (go && code == scp_pkg::CODE_PRECHARGE
		&& cmd_bus.addr_lines[scp_pkg::PRECHARGE_FLAG_POS] ##1 cmd_bus.cke |=> bank_open == 4'h0)
		else $error("banks left open");
	pre_one_a: assert property (go && code == scp_pkg::CODE_PRECHARGE
		&& !cmd_bus.addr_lines[scp_pkg::PRECHARGE_FLAG_POS] ##1 cmd_bus.cke
		|=> bank_open == ($past(bank_open) & ~(4'h1 << $past(cmd_bus.bank_select, 2))))
		else $error("wrong bank closed");
	read_oe_a: assert property (rd_cmd ##1 bank_open[$past(cmd_bus.bank_select)] && cmd_bus.cke
		##1 cmd_bus.cke |=> data_lines_oe == lane_oe($past(cmd_bus.byte_lane_mask, 3)))
		else $error("read lanes wrong");
	auto_pre_a: assert property (rd_cmd && cmd_bus.addr_lines[scp_pkg::PRECHARGE_FLAG_POS]
		##1 bank_open[$past(cmd_bus.bank_select)] && cmd_bus.cke ##1 cmd_bus.cke
		|=> !bank_open[$past(cmd_bus.bank_select, 3)]) else $error("auto close missing");
	lane_uniform_a: assert property (data_lines_oe
		== lane_oe(~{data_lines_oe[24], data_lines_oe[16], data_lines_oe[8], data_lines_oe[0]}))
		else $error("lane enable split");
endmodule

bind scp_cmd_port scp_cmd_port_props chk (.clk(clk), .rst(rst), .cmd_bus(cmd_bus), .data_lines_oe(data_lines_oe),
	.mode_opcode(mode_opcode), .mode_load(mode_load), .refresh_pulse(refresh_pulse), .bank_open(bank_open));

`default_nettype wire

// File: test/scp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module scp_ctl_model (
	// Clock
	input wire logic clk,
	// Pins toward the device
	output var scp_pkg::scp_cmd_bus_type bus,
	output var logic [scp_pkg::DATA_W-1:0] wdat
);
	initial
	begin
		bus = '0;
		bus.cke = 1'b1;
		bus.cs_n = 1'b1;
		wdat = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One command, strobes, bank and address held for exactly one edge
	task automatic cmd(input logic s, input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [3:0] m, input logic [31:0] d);
		@(posedge clk);
		bus.cs_n <= s;
		{bus.ras_n, bus.cas_n, bus.we_n} <= c;
		bus.bank_select <= b;
		bus.addr_lines <= a;
		bus.byte_lane_mask <= m;
		wdat <= d;
	endtask

	// Refresh taken on the same edge as the clock gate falls
	task automatic self_ref();
		@(posedge clk);
		bus.cke <= 1'b0;
		bus.cs_n <= 1'b0;
		{bus.ras_n, bus.cas_n, bus.we_n} <= scp_pkg::CODE_REFRESH;
	endtask

	// Idle data lines flip every cycle so stale data never looks valid
	task automatic nop(input int n, input logic k);
		repeat (n)
		begin
			@(posedge clk);
			bus.cs_n <= 1'b1;
			bus.cke <= k;
			{bus.ras_n, bus.cas_n, bus.we_n} <= scp_pkg::CODE_NOP;
			wdat <= ~wdat;
		end
	endtask
endmodule

`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) \
		begin \
			fails++; \
			$display("wrong value %s expected %h seen %h", w, e, g); \
		end \
	end

module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	int fails = 0;
	int cmp_count = 0;
	scp_pkg::scp_cmd_bus_type bus;
	logic [31:0] wdat, dq_o, dq_oe;
	logic [11:0] opc;
	logic ml, rp;
	logic [3:0] bo;
	scp_pkg::scp_pwr_type ps;

	always #12.5 clk = ~clk;

	scp_ctl_model ctl (.clk(clk), .bus(bus), .wdat(wdat));
	scp_cmd_port dut (.clk(clk), .rst(rst), .cmd_bus(bus), .data_lines_i(wdat), .data_lines_o(dq_o),
		.data_lines_oe(dq_oe), .mode_opcode(opc), .mode_load(ml), .refresh_pulse(rp), .bank_open(bo),
		.power_state(ps));

	////////////////////////////////////////////////////////////////////////////////
	// Masked lanes carry no defined data, so only enabled bytes are compared
	task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [3:0] m, input logic [31:0] d,
		input logic [31:0] oe);
		ctl.cmd(1'b0, scp_pkg::CODE_READ, b, a, m, 32'h0);
		ctl.nop(1, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		`CHK("oe", oe, dq_oe)
		`CHK("data", d & oe, dq_o & oe)
	endtask

	task automatic t_mode();
		ctl.cmd(1'b0, scp_pkg::CODE_LOAD_MODE, 2'h0, 12'ha5c, 4'h0, 32'h0);
		ctl.cmd(1'b0, scp_pkg::CODE_REFRESH, 2'h0, 12'h0, 4'h0, 32'h0);
		ctl.nop(1, 1'b1);
		#1;
		`CHK("load", 1'b1, ml)
		ctl.nop(1, 1'b1);
		#1;
		`CHK("refresh", 1'b1, rp)
		ctl.nop(1, 1'b1);
		`CHK("opcode", 12'ha5c, opc)
		ctl.cmd(1'b1, scp_pkg::CODE_LOAD_MODE, 2'h0, 12'h3c1, 4'h0, 32'h0);
		ctl.cmd(1'b1, scp_pkg::CODE_ACTIVATE, 2'h2, 12'h0, 4'h0, 32'h0);
		ctl.nop(3, 1'b1);
		`CHK("opcode", 12'ha5c, opc)
		`CHK("open", 4'h0, bo)
	endtask

	task automatic t_rw();
		for (int b = 0; b < 4; b++)
			ctl.cmd(1'b0, scp_pkg::CODE_ACTIVATE, 2'(b), 12'h7f0 | 12'(b), 4'h0, 32'h0);
		for (int b = 0; b < 4; b++)
			ctl.cmd(1'b0, scp_pkg::CODE_WRITE, 2'(b), 12'h003, 4'h0, 32'h1111_1111 * (b + 1));
		ctl.cmd(1'b0, scp_pkg::CODE_WRITE, 2'h2, 12'h003, 4'h5, 32'hffff_ffff);
		ctl.cmd(1'b0, scp_pkg::CODE_WRITE, 2'h0, 12'h004, 4'h0, 32'h0bad_f00d);
		ctl.nop(2, 1'b1);
		`CHK("open", 4'hf, bo)
		rd(2'h0, 12'h003, 4'h0, 32'h1111_1111, 32'hffff_ffff);
		rd(2'h1, 12'h003, 4'hf, 32'h2222_2222, 32'h0);
		rd(2'h2, 12'h003, 4'h0, 32'hff33_ff33, 32'hffff_ffff);
		rd(2'h3, 12'h003, 4'ha, 32'h4444_4444, 32'h00ff_00ff);
		rd(2'h0, 12'h004, 4'h0, 32'h0bad_f00d, 32'hffff_ffff);
		`CHK("open", 4'hf, bo)
	endtask

	task automatic t_pre();
		ctl.cmd(1'b0, scp_pkg::CODE_PRECHARGE, 2'h1, 12'h000, 4'h0, 32'h0);
		ctl.nop(2, 1'b1);
		#1;
		`CHK("open", 4'hd, bo)
		rd(2'h1, 12'h003, 4'h0, 32'h0, 32'h0);
		rd(2'h3, 12'h403, 4'h0, 32'h4444_4444, 32'hffff_ffff);
		#1;
		`CHK("open", 4'h5, bo)
		ctl.cmd(1'b0, scp_pkg::CODE_PRECHARGE, 2'h0, 12'h400, 4'h0, 32'h0);
		ctl.nop(2, 1'b1);
		#1;
		`CHK("open", 4'h0, bo)
	endtask

	task automatic t_pwr();
		ctl.nop(4, 1'b0);
		#1;
		`CHK("power", scp_pkg::PWR_DOWN_PRECHARGE, ps)
		ctl.nop(2, 1'b1);
		ctl.cmd(1'b0, scp_pkg::CODE_ACTIVATE, 2'h1, 12'h0, 4'h0, 32'h0);
		ctl.nop(2, 1'b1);
		ctl.nop(4, 1'b0);
		#1;
		`CHK("power", scp_pkg::PWR_DOWN_ACTIVE, ps)
		ctl.nop(3, 1'b1);
		#1;
		`CHK("power", scp_pkg::PWR_ACTIVE, ps)
		// Read in flight when the gate drops: suspend, then finish on resume
		ctl.cmd(1'b0, scp_pkg::CODE_READ, 2'h1, 12'h000, 4'h0, 32'h0);
		ctl.nop(2, 1'b0);
		#1;
		`CHK("power", scp_pkg::PWR_CLOCK_SUSPEND, ps)
		ctl.nop(3, 1'b1);
		#1;
		`CHK("oe", 32'hffff_ffff, dq_oe)
		ctl.self_ref();
		ctl.nop(2, 1'b0);
		#1;
		`CHK("power", scp_pkg::PWR_SELF_REFRESH, ps)
		ctl.nop(3, 1'b1);
		#1;
		`CHK("power", scp_pkg::PWR_ACTIVE, ps)
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Whole run is about a hundred cycles; generous margin
	initial
	begin
		#50us;
		fails++;
		conclude();
	end

	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_mode();
		t_rw();
		t_pre();
		t_pwr();
		conclude();
	end
endmodule

`default_nettype wire
